/* File: src/ddsc_pkg.sv */
// Operation
// (RULE1) divider select divides the oscillator by two to its power, zero by one, max 512
// (RULE2) divider codes ten to fifteen act exactly like the maximum code nine
// (RULE3) each divider step up doubles the output period, each step down halves it
// (RULE4) divider select moves only by carry or borrow out of stage select adjustments
// (RULE5) upper three stage bits give ring period 17 to 31 delays in steps of two
// (RULE6) per 32 output cycles, lower stage bits count the cycles run two stages longer
// (RULE7) coarse code all ones alternates 31 stages with 17 stages plus divide-by-two
// (RULE8) above 15 percent error each correction moves stage select by its bit five
// (RULE9) at most one correction per four base clock periods
// (RULE10) in the coarse band eight corrections double or halve the output period
// (RULE11) between 15 and 5 percent each correction shifts the period about two percent
// (RULE12) stable flag rises once the error is below 5 percent
// (RULE13) below 5 percent corrections move only stage bit zero, 24 reach the minimum
// (RULE14) loop regulates internal clock to multiplier times the 307.2 kHz base clock
// (RULE15) software checks fail flag, disables monitor, changes multiplier, then re-enables
// (RULE16) monitor enable is refused until the stable flag is set again
// (RULE17) settling restarts after reset, multiplier or trim change, and clock re-enable
// (RULE18) monitor enable takes effect only with both clocks on and stable
// (RULE19) loop state is one twelve-bit value, divider select above stage select
package ddsc_pkg;
	localparam int BASE_FREQ_HZ = 307200;
	localparam int CORRECTION_BASE_PERIODS = 4;
	localparam logic [1:0] CORRECTION_LAST = 2'(CORRECTION_BASE_PERIODS - 1);
	localparam logic [4:0] RING_MIN_STAGES = 5'h11;
	localparam logic [4:0] RING_MAX_STAGES = 5'h1F;
	localparam logic [2:0] COARSE_TOP = 3'h7;
	localparam logic [3:0] DIV_MAX = 4'h9;
	localparam logic [11:0] LOOP_MAX = 12'h9FF;
	localparam logic [11:0] STEP_COARSE = 12'h020;
	localparam logic [11:0] STEP_MID = 12'h008;
	localparam logic [11:0] STEP_FINE = 12'h001;
	localparam logic [1:0] BAND_FINE = 2'h0;
	localparam logic [1:0] BAND_MID = 2'h1;
	localparam logic [1:0] BAND_COARSE = 2'h2;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_TRIM = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
	localparam logic [4:0] OFS_LOOP = 5'h14;
	localparam int CTRL_MULT_LSB = 0;
	localparam int CTRL_INT_ON = 8;
	localparam int CTRL_MON_EN = 9;
	localparam int STAT_STABLE = 0;
	localparam int STAT_EXT_STABLE = 1;
	localparam int STAT_FAIL = 2;
	localparam int STAT_INT_ON = 3;
	localparam int IRQ_STABLE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_REFUSED = 2;
	localparam logic [6:0] MULT_RESET = 7'h15;
	localparam logic [7:0] TRIM_RESET = 8'h80;
	localparam logic [11:0] LOOP_RESET = 12'h000;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writeData;
		logic [3:0] byteEnable;
	} ddsc_avl_req_s;

	typedef struct packed {
		logic [1:0] band;
		logic periodShort;
		logic monitorFail;
		logic extStable;
		logic extOn;
		logic baseClock;
		logic fastClock;
	} ddsc_pins_s;
endpackage

/* File: src/ddsc_dco_control.sv */
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module ddsc_dco_control (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic lowFreqBaseClock,
	input wire logic internalFastClock,
	input wire logic [1:0] errorBand,
	input wire logic periodShort,
	input wire logic monitorFailIn,
	input wire logic extClockStable,
	input wire logic extClockOn,
	output logic [3:0] oscDividerSelect,
	output logic [4:0] ringStages,
	output logic ringHalve,
	output logic [11:0] loopFilter,
	output logic [6:0] multiplier,
	output logic [7:0] trim,
	output logic internalClockOn,
	output logic internalClockStableFlag,
	output logic clockMonitorEnable,
	output logic monitorFailFlag,
	output logic irq
);
	typedef struct packed {
		ddsc_pkg::ddsc_pins_s pinsMeta;
		ddsc_pkg::ddsc_pins_s pinsSync;
		logic basePrev;
		logic fastPrev;
		logic [1:0] baseCount;
		logic [11:0] loopValue;
		logic [4:0] ditherCount;
		logic [3:0] divSelect;
		logic [4:0] ringStages;
		logic ringHalve;
		logic stable;
		logic [6:0] multiplier;
		logic [7:0] trim;
		logic intOn;
		logic monitorOn;
		logic [2:0] irqStatus;
		logic [2:0] irqMask;
		logic irq;
		logic waitReq;
		logic [31:0] readData;
	} ddsc_state_s;

	ddsc_state_s state;
	ddsc_state_s next_state;
	ddsc_pkg::ddsc_avl_req_s req;
	ddsc_pkg::ddsc_pins_s pinsIn;

	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writeData: avs_writedata, byteEnable: avs_byteenable};
	assign pinsIn = '{band: errorBand, periodShort: periodShort, monitorFail: monitorFailIn,
		extStable: extClockStable, extOn: extClockOn, baseClock: lowFreqBaseClock,
		fastClock: internalFastClock};

	// codes above nine behave as nine; each step doubles the period
	function automatic logic [3:0] effectiveDiv(input logic [3:0] code);
		effectiveDiv = (code > ddsc_pkg::DIV_MAX) ? ddsc_pkg::DIV_MAX : code; // [RULE1] [RULE2] [RULE3]
	endfunction

	// byte-lane merge of a write into an old register value
	function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] lanes);
		mergeLanes = old;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				mergeLanes[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	// saturating step of the combined loop value; overflow walks into the divider field
	function automatic logic [11:0] stepLoop(input logic [11:0] value, input logic [11:0] step,
			input logic up);
		logic [12:0] sum;
		sum = 13'h0000;
		if (up) begin
			sum = {1'b0, value} + {1'b0, step};
			stepLoop = (sum > {1'b0, ddsc_pkg::LOOP_MAX}) ? ddsc_pkg::LOOP_MAX : sum[11:0];
		end else begin
			stepLoop = (value < step) ? 12'h000 : value - step;
		end
	endfunction

	logic baseEdge;
	logic fastEdge;
	logic correctionTick;
	logic [2:0] coarse;
	logic [4:0] fine;
	logic longCycle;
	logic [31:0] ctrlWord;
	logic [31:0] ctrlNew;
	logic [31:0] statusWord;
	logic [31:0] loopWord;
	logic accessEdge;
	logic ctrlWrite;
	logic restart;
	logic monitorAllowed;
	logic monitorRequest;
	logic failEvent;
	logic [2:0] irqEvents;
	logic [2:0] irqClear;
	logic [11:0] stepSize;
	logic [7:0] trimNew;
	logic [31:0] trimMerged;

	always_comb begin
		next_state = state;
		// first sync stage feeds only the second stage
		next_state.pinsMeta = pinsIn;
		next_state.pinsSync = state.pinsMeta;
		next_state.basePrev = state.pinsSync.baseClock;
		next_state.fastPrev = state.pinsSync.fastClock;
		baseEdge = state.pinsSync.baseClock & ~state.basePrev;
		fastEdge = state.pinsSync.fastClock & ~state.fastPrev;

		// bus: waitrequest drops for one cycle, access lands on that edge
		accessEdge = (req.read | req.write) & ~state.waitReq;
		ctrlWord = 32'h0000_0000;
		ctrlWord[ddsc_pkg::CTRL_MULT_LSB +: 7] = state.multiplier;
		ctrlWord[ddsc_pkg::CTRL_INT_ON] = state.intOn;
		ctrlWord[ddsc_pkg::CTRL_MON_EN] = state.monitorOn;
		statusWord = 32'h0000_0000;
		statusWord[ddsc_pkg::STAT_STABLE] = state.stable;
		statusWord[ddsc_pkg::STAT_EXT_STABLE] = state.pinsSync.extStable;
		statusWord[ddsc_pkg::STAT_FAIL] = state.irqStatus[ddsc_pkg::IRQ_FAIL];
		statusWord[ddsc_pkg::STAT_INT_ON] = state.intOn;
		loopWord = {16'h0000, effectiveDiv(state.loopValue[11:8]), state.loopValue};
		ctrlNew = mergeLanes(ctrlWord, req.writeData, req.byteEnable);
		trimMerged = mergeLanes({24'h000000, state.trim}, req.writeData, req.byteEnable);
		trimNew = trimMerged[7:0];
		ctrlWrite = accessEdge & req.write & (req.address == ddsc_pkg::OFS_CTRL);

		if ((req.read | req.write) & state.waitReq) begin
			next_state.waitReq = 1'b0;
			case (req.address)
				ddsc_pkg::OFS_CTRL: next_state.readData = ctrlWord;
				ddsc_pkg::OFS_TRIM: next_state.readData = {24'h000000, state.trim};
				ddsc_pkg::OFS_STATUS: next_state.readData = statusWord;
				ddsc_pkg::OFS_IRQ_STATUS: next_state.readData = {29'h00000000, state.irqStatus};
				ddsc_pkg::OFS_IRQ_MASK: next_state.readData = {29'h00000000, state.irqMask};
				ddsc_pkg::OFS_LOOP: next_state.readData = loopWord;
				default: next_state.readData = 32'h0000_0000;
			endcase
		end else if (accessEdge) begin
			next_state.waitReq = 1'b1;
		end

		// the settling restarts on new multiplier, new trim or internal clock re-enable
		restart = 1'b0;
		if (ctrlWrite) begin
			next_state.multiplier = ctrlNew[ddsc_pkg::CTRL_MULT_LSB +: 7]; // [RULE14]
			next_state.intOn = ctrlNew[ddsc_pkg::CTRL_INT_ON];
			if (ctrlNew[ddsc_pkg::CTRL_MULT_LSB +: 7] != state.multiplier) begin
				restart = 1'b1; // [RULE17]
			end
			if (ctrlNew[ddsc_pkg::CTRL_INT_ON] & ~state.intOn) begin
				restart = 1'b1; // [RULE17]
			end
		end
		if (accessEdge & req.write & (req.address == ddsc_pkg::OFS_TRIM)) begin
			next_state.trim = trimNew;
			if (trimNew != state.trim) begin
				restart = 1'b1; // [RULE17]
			end
		end
		if (accessEdge & req.write & (req.address == ddsc_pkg::OFS_IRQ_MASK)) begin
			next_state.irqMask = req.byteEnable[0] ? req.writeData[2:0] : state.irqMask;
		end

		// loop filter paced by base clock periods; disabled clock means no corrections
		correctionTick = 1'b0;
		if (restart | ~next_state.intOn) begin
			next_state.baseCount = 2'h0;
		end else if (baseEdge) begin
			if (state.baseCount == ddsc_pkg::CORRECTION_LAST) begin
				next_state.baseCount = 2'h0;
				correctionTick = 1'b1; // [RULE9]
			end else begin
				next_state.baseCount = state.baseCount + 2'h1;
			end
		end

		case (state.pinsSync.band)
			ddsc_pkg::BAND_FINE: stepSize = ddsc_pkg::STEP_FINE; // [RULE13]
			ddsc_pkg::BAND_MID: stepSize = ddsc_pkg::STEP_MID; // [RULE11]
			default: stepSize = ddsc_pkg::STEP_COARSE; // [RULE8] [RULE10]
		endcase
		if (correctionTick) begin
			// one value: stage carry or borrow is what moves the divider
			next_state.loopValue = stepLoop(state.loopValue, stepSize,
				state.pinsSync.periodShort); // [RULE4] [RULE19]
			if (state.pinsSync.band == ddsc_pkg::BAND_FINE) begin
				next_state.stable = 1'b1; // [RULE12]
			end
		end
		if (restart | ~next_state.intOn) begin
			next_state.stable = 1'b0; // [RULE17]
		end

		// dither over 32 output cycles; sampling limits tracking to below mclk/2
		coarse = state.loopValue[7:5];
		fine = state.loopValue[4:0];
		if (fastEdge) begin
			next_state.ditherCount = state.ditherCount + 5'h01;
		end
		longCycle = state.ditherCount < fine; // [RULE6]
		next_state.divSelect = effectiveDiv(state.loopValue[11:8]); // [RULE1] [RULE2]
		if (coarse == ddsc_pkg::COARSE_TOP) begin
			next_state.ringStages = longCycle ? ddsc_pkg::RING_MIN_STAGES
				: ddsc_pkg::RING_MAX_STAGES; // [RULE7]
			next_state.ringHalve = longCycle; // [RULE7]
		end else begin
			next_state.ringStages = ddsc_pkg::RING_MIN_STAGES + {1'b0, coarse, 1'b0}
				+ (longCycle ? 5'h02 : 5'h00); // [RULE5] [RULE6]
			next_state.ringHalve = 1'b0;
		end

		// monitor enable needs both clocks on and stable, else refused
		monitorAllowed = next_state.intOn & state.stable & state.pinsSync.extOn
			& state.pinsSync.extStable; // [RULE18]
		monitorRequest = ctrlWrite & ctrlNew[ddsc_pkg::CTRL_MON_EN] & ~state.monitorOn;
		if (ctrlWrite & ~ctrlNew[ddsc_pkg::CTRL_MON_EN]) begin
			next_state.monitorOn = 1'b0;
		end else if (monitorRequest) begin
			next_state.monitorOn = monitorAllowed; // [RULE16] [RULE18]
		end
		if (~next_state.intOn | ~state.pinsSync.extOn) begin
			next_state.monitorOn = 1'b0; // [RULE18]
		end

		failEvent = state.monitorOn & state.pinsSync.monitorFail;
		irqEvents = 3'h0;
		irqEvents[ddsc_pkg::IRQ_STABLE] = next_state.stable & ~state.stable;
		irqEvents[ddsc_pkg::IRQ_FAIL] = failEvent;
		irqEvents[ddsc_pkg::IRQ_REFUSED] = monitorRequest & ~monitorAllowed; // [RULE16]
		irqClear = 3'h0;
		if (accessEdge & req.write & (req.address == ddsc_pkg::OFS_IRQ_STATUS)
				& req.byteEnable[0]) begin
			irqClear = req.writeData[2:0];
		end
		// a new event in the clearing cycle stays set
		next_state.irqStatus = (state.irqStatus & ~irqClear) | irqEvents;
		next_state.irq = |(next_state.irqStatus & next_state.irqMask);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
			state.waitReq <= 1'b1;
			state.multiplier <= ddsc_pkg::MULT_RESET;
			state.trim <= ddsc_pkg::TRIM_RESET;
			state.intOn <= 1'b1;
			state.loopValue <= ddsc_pkg::LOOP_RESET;
			state.irqMask <= ddsc_pkg::IRQ_MASK_RESET;
			state.ringStages <= ddsc_pkg::RING_MIN_STAGES; // [RULE17]
		end else if (clkEn) begin
			state <= next_state;
		end
	end

	assign avs_readdata = state.readData;
	assign avs_waitrequest = state.waitReq;
	assign oscDividerSelect = state.divSelect;
	assign ringStages = state.ringStages;
	assign ringHalve = state.ringHalve;
	assign loopFilter = state.loopValue;
	assign multiplier = state.multiplier;
	assign trim = state.trim;
	assign internalClockOn = state.intOn;
	assign internalClockStableFlag = state.stable;
	assign clockMonitorEnable = state.monitorOn;
	assign monitorFailFlag = state.irqStatus[ddsc_pkg::IRQ_FAIL];
	assign irq = state.irq;
endmodule

/* File: sim/ddsc_dco_control_properties.sv */
`timescale 1ns/100ps
module ddsc_dco_control_properties (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic extClockOn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [3:0] oscDividerSelect,
	input wire logic [4:0] ringStages,
	input wire logic ringHalve,
	input wire logic [11:0] loopFilter,
	input wire logic [6:0] multiplier,
	input wire logic [7:0] trim,
	input wire logic internalClockOn,
	input wire logic internalClockStableFlag,
	input wire logic clockMonitorEnable
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// two quiet cycles let the registered divider catch up with the loop value
	sequence s_held;
		$stable(loopFilter) [*2];
	endsequence
	a_bus_answer: assert property (s_req |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	a_div_follow: assert property (s_held |-> oscDividerSelect == loopFilter[11:8])
		else $error("divider select not loop field");
	a_ring_span: assert property (ringStages >= ddsc_pkg::RING_MIN_STAGES && ringStages[0] &&
		ringStages <= ddsc_pkg::RING_MAX_STAGES)
		else $error("ring stages out of range");
	a_halve_short: assert property (ringHalve |-> ringStages == ddsc_pkg::RING_MIN_STAGES)
		else $error("halved cycle not shortest ring");
	a_step_size: assert property ($changed(loopFilter) |-> loopFilter inside {12'h000, 12'h9FF} ||
		12'(loopFilter - $past(loopFilter)) inside {12'h001, 12'h008, 12'h020, 12'hFFF,
		12'hFF8, 12'hFE0})
		else $error("loop step size wrong");
	a_pace_gap: assert property ($changed(loopFilter) |=> $stable(loopFilter) [*8])
		else $error("corrections too close");
	a_mon_gate: assert property ($rose(clockMonitorEnable) |->
		$past(internalClockStableFlag) && $past(internalClockOn))
		else $error("monitor enabled while unstable");
	a_off_mon: assert property (!internalClockOn |=> !clockMonitorEnable)
		else $error("monitor on with clock off");
	// the external clock pin passes two sync flops before it forces the monitor off
	a_ext_off_mon: assert property ((!extClockOn && clkEn) [*3] |=> !clockMonitorEnable)
		else $error("monitor on with external clock off");
	a_off_unstable: assert property (!internalClockOn |=> !internalClockStableFlag)
		else $error("stable with clock off");
	a_restart_clear: assert property (($changed(multiplier) || $changed(trim)) |->
		##[0:1] !internalClockStableFlag)
		else $error("no restart after change");
endmodule

/* File: sim/ddsc_dco_control_bench.sv */
`timescale 1ns/100ps
module ddsc_dco_control_bench;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic lowFreqBaseClock = 1'b0;
	logic internalFastClock = 1'b0;
	logic [1:0] errorBand = 2'h0;
	logic periodShort = 1'b0;
	logic monitorFail = 1'b0;
	logic extClockOn = 1'b1;
	logic monitorFailFlag;
	logic [3:0] oscDividerSelect;
	logic [4:0] ringStages;
	logic ringHalve;
	logic [11:0] loopFilter;
	logic [6:0] multiplier;
	logic [7:0] trim;
	logic internalClockOn;
	logic internalClockStableFlag;
	logic clockMonitorEnable;
	logic irq;
	logic [2:0] phase = 3'h0;
	logic [31:0] rd;
	int n_fail = 0;
	int checks_done = 0;
	int cnt;

	ddsc_dco_control u_dut (
		.mclk, .reset_n, .clkEn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .lowFreqBaseClock,
		.internalFastClock, .errorBand, .periodShort, .monitorFailIn(monitorFail),
		.extClockStable(1'b1), .extClockOn, .oscDividerSelect, .ringStages, .ringHalve,
		.loopFilter, .multiplier, .trim, .internalClockOn, .internalClockStableFlag,
		.clockMonitorEnable, .monitorFailFlag, .irq
	);

	always #10 mclk = ~mclk;

	// base clock 8 cycles, fast clock 4: both slow enough for the two-flop sync
	always @(posedge mclk) begin
		phase <= phase + 3'h1;
		lowFreqBaseClock <= phase[2];
		internalFastClock <= phase[1];
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// the idle edge first keeps a released strobe from being raised in the same step
	task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
		int t = 0;
		@(posedge mclk);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
			t++;
		end while (avs_waitrequest !== 1'b0 && t < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (t >= 20) n_fail++;
	endtask

	task automatic wait_for(input logic [11:0] v);
		int t = 0;
		while (loopFilter !== v && t < 4000) begin
			@(posedge mclk);
			t++;
		end
		chk("loop value", {20'h0, v}, {20'h0, loopFilter});
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		bus(1'b0, ddsc_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0000_0115, rd);
		bus(1'b0, ddsc_pkg::OFS_TRIM, 32'h0);
		chk("trim", 32'h0000_0080, rd);
		bus(1'b0, 5'h18, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("stable", 32'h0, {31'h0, internalClockStableFlag});
		$display("test reset done");
		errorBand <= ddsc_pkg::BAND_COARSE;
		periodShort <= 1'b1;
		wait_for(12'h100);
		bus(1'b0, ddsc_pkg::OFS_LOOP, 32'h0);
		chk("loop reg", 32'h0000_1100, rd);
		chk("divider", 32'h1, {28'h0, oscDividerSelect});
		chk("ring", 32'h11, {27'h0, ringStages});
		// frozen clock enable must hold the loop although corrections are due
		clkEn <= 1'b0;
		repeat (64) @(posedge mclk);
		chk("frozen loop", 32'h100, {20'h0, loopFilter});
		clkEn <= 1'b1;
		$display("test coarse done");
		errorBand <= ddsc_pkg::BAND_MID;
		periodShort <= 1'b0;
		wait_for(12'h0F8);
		chk("stable", 32'h0, {31'h0, internalClockStableFlag});
		errorBand <= ddsc_pkg::BAND_FINE;
		wait_for(12'h0F7);
		repeat (3) @(posedge mclk);
		chk("stable", 32'h1, {31'h0, internalClockStableFlag});
		chk("divider", 32'h0, {28'h0, oscDividerSelect});
		$display("test fine done");
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0315);
		repeat (2) @(posedge mclk);
		chk("monitor", 32'h1, {31'h0, clockMonitorEnable});
		monitorFail <= 1'b1;
		repeat (5) @(posedge mclk);
		monitorFail <= 1'b0;
		chk("fail flag", 32'h1, {31'h0, monitorFailFlag});
		bus(1'b0, ddsc_pkg::OFS_STATUS, 32'h0);
		chk("status", 32'h0000_000F, rd);
		bus(1'b1, ddsc_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0115);
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0120);
		repeat (2) @(posedge mclk);
		chk("monitor", 32'h0, {31'h0, clockMonitorEnable});
		chk("fail flag", 32'h0, {31'h0, monitorFailFlag});
		chk("stable", 32'h0, {31'h0, internalClockStableFlag});
		chk("multiplier", 32'h20, {25'h0, multiplier});
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0320);
		repeat (2) @(posedge mclk);
		chk("monitor", 32'h0, {31'h0, clockMonitorEnable});
		bus(1'b0, ddsc_pkg::OFS_IRQ_STATUS, 32'h0);
		chk("irq status", 32'h0000_0005, rd);
		bus(1'b1, ddsc_pkg::OFS_IRQ_MASK, 32'h0000_0004);
		repeat (2) @(posedge mclk);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, ddsc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
		repeat (2) @(posedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		// a fine correction is due within four base periods of the restart
		repeat (16) @(posedge mclk);
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0320);
		repeat (2) @(posedge mclk);
		chk("monitor", 32'h1, {31'h0, clockMonitorEnable});
		extClockOn <= 1'b0;
		repeat (5) @(posedge mclk);
		chk("monitor", 32'h0, {31'h0, clockMonitorEnable});
		extClockOn <= 1'b1;
		bus(1'b1, ddsc_pkg::OFS_TRIM, 32'h0000_0081);
		repeat (2) @(posedge mclk);
		chk("trim", 32'h81, {24'h0, trim});
		chk("stable", 32'h0, {31'h0, internalClockStableFlag});
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0020);
		repeat (2) @(posedge mclk);
		chk("clock on", 32'h0, {31'h0, internalClockOn});
		bus(1'b1, ddsc_pkg::OFS_CTRL, 32'h0000_0120);
		$display("test monitor done");
		errorBand <= 2'h3;
		periodShort <= 1'b1;
		wait_for(12'h9FF);
		repeat (3) @(posedge mclk);
		chk("divider", 32'h9, {28'h0, oscDividerSelect});
		// 128 cycles span exactly 32 fast periods of 4 cycles, whatever the phase
		cnt = 0;
		repeat (128) begin
			@(posedge mclk);
			if (ringHalve === 1'b1) cnt++;
		end
		chk("halved cycles", 32'd124, 32'(cnt));
		chk("saturated", 32'h9FF, {20'h0, loopFilter});
		$display("test saturate done");
		end_of_test();
	end
endmodule

bind ddsc_dco_control ddsc_dco_control_properties u_props (
	.mclk, .reset_n, .clkEn, .extClockOn, .avs_read, .avs_write, .avs_waitrequest,
	.oscDividerSelect, .ringStages,
	.ringHalve, .loopFilter, .multiplier, .trim, .internalClockOn, .internalClockStableFlag,
	.clockMonitorEnable
);
